// [hdl/tmwc_ahb_slave.sv]
`timescale 1ns/10ps
module tmwc_ahb_slave (
  input  wire logic                   clk_in,
  input  wire logic                   nrst_in,
  input  wire logic                   hsel_in,
  input  wire logic [31:0]            haddr_in,
  input  wire logic [1:0]             htrans_in,
  input  wire logic                   hwrite_in,
  input  wire logic                   hready_in,
  output tmwc_pkg::tmwc_bus_req_t     ap_req_out,
  output logic                        wr_en_out,
  output logic [7:0]                  wr_addr_out,
  output logic                        hreadyout_out,
  output logic                        hresp_out
);
  tmwc_pkg::tmwc_slv_state_t st_ff;
  tmwc_pkg::tmwc_slv_state_t nxt_st;

  // NONSEQ or SEQ accepted while the bus is ready
  always_comb begin
    ap_req_out.valid = hsel_in && htrans_in[1] && hready_in;
    ap_req_out.write = hwrite_in;
    ap_req_out.addr  = haddr_in[7:0];
    nxt_st           = st_ff;
    nxt_st.wr_pend   = ap_req_out.valid && hwrite_in;
    if (ap_req_out.valid) begin
      nxt_st.wr_addr = haddr_in[7:0];
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Zero wait states, always OKAY
  assign hreadyout_out = 1'b1;
  assign hresp_out     = 1'b0;
  assign wr_en_out     = st_ff.wr_pend;
  assign wr_addr_out   = st_ff.wr_addr;
endmodule : tmwc_ahb_slave

// [hdl/tmwc_defines.svh]
`ifndef TMWC_DEFINES_SVH
`define TMWC_DEFINES_SVH

// Register byte offsets
`define TMWC_OFF_CTRL      8'h00
`define TMWC_OFF_COUNT     8'h04
`define TMWC_OFF_COMPARE   8'h08
`define TMWC_OFF_STATUS    8'h0c
`define TMWC_OFF_PORT      8'h10

// Control register fields
`define TMWC_CTRL_WAVE_LSB 0
`define TMWC_CTRL_COM_LSB  4
`define TMWC_CTRL_FORCE    7

// Status register fields, write one to clear
`define TMWC_STAT_OVF      0
`define TMWC_STAT_MATCH    1

// Port register fields
`define TMWC_PORT_DATA     0
`define TMWC_PORT_DIR      1
`define TMWC_PORT_PIN      2

// Counter extremes and reset values
`define TMWC_MAX           8'hff
`define TMWC_BOTTOM        8'h00
`define TMWC_RST_BYTE      8'h00
`define TMWC_RST_WORD      32'h0000_0000

`endif

// [hdl/tmwc_pkg.sv]
package tmwc_pkg;

  typedef enum logic [1:0] {
    WM_NORMAL = 2'b00,
    WM_PHASE  = 2'b01,
    WM_CTC    = 2'b10,
    WM_FAST   = 2'b11
  } tmwc_wave_t;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] addr;
  } tmwc_bus_req_t;

  typedef struct packed {
    logic       wr_pend;
    logic [7:0] wr_addr;
  } tmwc_slv_state_t;

  typedef struct packed {
    tmwc_wave_t  wave_mode;
    logic [1:0]  com;
    logic [7:0]  count;
    logic [7:0]  ocr_act;
    logic [7:0]  ocr_buf;
    logic        ovf;
    logic        mtf;
    logic        oc;
    logic        block;
    logic        port_data;
    logic        dir;
    logic        pin_lvl;
    logic        pin_drive;
    logic [31:0] rdata;
  } tmwc_state_t;

endpackage : tmwc_pkg

// [hdl/tmwc_sync3.sv]
`timescale 1ns/10ps
module tmwc_sync3 (
  input  wire logic clk_in,
  input  wire logic nrst_in,
  input  wire logic async_in,
  output logic      sync_out
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic out_ff;

  // Level changes only when the last two stages agree
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      s1_ff  <= 1'b0;
      s2_ff  <= 1'b0;
      s3_ff  <= 1'b0;
      out_ff <= 1'b0;
    end else begin
      s1_ff <= async_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (s2_ff == s3_ff) begin
        out_ff <= s3_ff;
      end
    end
  end

  assign sync_out = out_ff;
endmodule : tmwc_sync3

// [hdl/tmwc_top.sv]
`timescale 1ns/10ps
`include "tmwc_defines.svh"

module tmwc_top (
  input  wire logic        clk_in,
  input  wire logic        nrst_in,
  input  wire logic        timer_tick_in,
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic        hready_in,
  input  wire logic [31:0] hwdata_in,
  output logic      [31:0] hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  input  wire logic        pin_in,
  output logic             pin_out,
  output logic             pin_oe_out,
  output logic             overflow_flag_out,
  output logic             match_flag_out
);

  tmwc_pkg::tmwc_state_t   st_ff;
  tmwc_pkg::tmwc_state_t   nxt_st;
  tmwc_pkg::tmwc_bus_req_t ap_req;
  logic                    wr_en;
  logic [7:0]              wr_addr;
  logic                    pin_sync;
  logic                    at_max;
  logic                    hit;
  logic                    forced;
  logic [1:0]              wr_com;

  // Only whole-word transfers are supported, size is not checked
  logic                    unused_size;
  assign unused_size = ^hsize_in;

  tmwc_ahb_slave u_slave (
    .clk_in        (clk_in),
    .nrst_in       (nrst_in),
    .hsel_in       (hsel_in),
    .haddr_in      (haddr_in),
    .htrans_in     (htrans_in),
    .hwrite_in     (hwrite_in),
    .hready_in     (hready_in),
    .ap_req_out    (ap_req),
    .wr_en_out     (wr_en),
    .wr_addr_out   (wr_addr),
    .hreadyout_out (hreadyout_out),
    .hresp_out     (hresp_out)
  );

  tmwc_sync3 u_pin_sync (
    .clk_in   (clk_in),
    .nrst_in  (nrst_in),
    .async_in (pin_in),
    .sync_out (pin_sync)
  );

  function automatic logic is_pwm(input tmwc_pkg::tmwc_wave_t mode);
    is_pwm = (mode == tmwc_pkg::WM_PHASE) || (mode == tmwc_pkg::WM_FAST);
  endfunction : is_pwm

  // Match action outside PWM: keep, toggle, clear, set
  function automatic logic match_action(input logic [1:0] com,
                                        input logic       oc);
    case (com)
      2'h1:    match_action = ~oc;
      2'h2:    match_action = 1'b0;
      2'h3:    match_action = 1'b1;
      default: match_action = oc;
    endcase
  endfunction : match_action

  function automatic logic [31:0] read_mux(input logic [7:0]           addr,
                                           input tmwc_pkg::tmwc_state_t s);
    read_mux = `TMWC_RST_WORD;
    case (addr)
      `TMWC_OFF_CTRL: begin
        // Force strobe always reads zero
        read_mux[`TMWC_CTRL_WAVE_LSB +: 2] = s.wave_mode;
        read_mux[`TMWC_CTRL_COM_LSB +: 2]  = s.com;
      end
      `TMWC_OFF_COUNT: begin
        read_mux[7:0] = s.count;
      end
      `TMWC_OFF_COMPARE: begin
        read_mux[7:0] = s.ocr_buf;
      end
      `TMWC_OFF_STATUS: begin
        read_mux[`TMWC_STAT_OVF]   = s.ovf;
        read_mux[`TMWC_STAT_MATCH] = s.mtf;
      end
      `TMWC_OFF_PORT: begin
        read_mux[`TMWC_PORT_DATA] = s.port_data;
        read_mux[`TMWC_PORT_DIR]  = s.dir;
        read_mux[`TMWC_PORT_PIN]  = s.pin_lvl;
      end
      default: begin
        read_mux = `TMWC_RST_WORD;
      end
    endcase
  endfunction : read_mux

  always_comb begin
    nxt_st = st_ff;
    at_max = (st_ff.count == `TMWC_MAX);
    // A count write blocks the match of the following tick
    hit    = (st_ff.count == st_ff.ocr_act) && !st_ff.block;
    wr_com = hwdata_in[`TMWC_CTRL_COM_LSB +: 2];
    forced = wr_en && (wr_addr == `TMWC_OFF_CTRL)
             && hwdata_in[`TMWC_CTRL_FORCE]
             && !is_pwm(tmwc_pkg::tmwc_wave_t'(
                  hwdata_in[`TMWC_CTRL_WAVE_LSB +: 2]));

    // Software clear first so a same-cycle set wins
    if (wr_en && (wr_addr == `TMWC_OFF_STATUS)) begin
      if (hwdata_in[`TMWC_STAT_OVF]) begin
        nxt_st.ovf = 1'b0;
      end
      if (hwdata_in[`TMWC_STAT_MATCH]) begin
        nxt_st.mtf = 1'b0;
      end
    end

    if (timer_tick_in) begin
      nxt_st.block = 1'b0;
      // Counting depends on waveform mode only
      case (st_ff.wave_mode)
        tmwc_pkg::WM_CTC: begin
          if (hit) begin
            nxt_st.count = `TMWC_BOTTOM;
          end else begin
            nxt_st.count = st_ff.count + 8'h01;
          end
        end
        tmwc_pkg::WM_FAST: begin
          nxt_st.count = st_ff.count + 8'h01;
        end
        default: begin
          // Dual slope not covered here, counts as normal
          nxt_st.count = st_ff.count + 8'h01;
        end
      endcase

      // Flag set when passing from max to bottom
      if (at_max) begin
        nxt_st.ovf = 1'b1;
      end
      if (hit) begin
        nxt_st.mtf = 1'b1;
      end

      case (st_ff.wave_mode)
        tmwc_pkg::WM_NORMAL,
        tmwc_pkg::WM_CTC: begin
          if (hit) begin
            // Toggle gives period 2*N*(1+compare) in CTC, 2*N*256 in normal
            nxt_st.oc = match_action(st_ff.com, st_ff.oc);
          end
        end
        tmwc_pkg::WM_FAST: begin
          if (hit) begin
            case (st_ff.com)
              2'h1:    nxt_st.oc = ~st_ff.oc;
              2'h2:    nxt_st.oc = 1'b0;
              2'h3:    nxt_st.oc = 1'b1;
              default: nxt_st.oc = st_ff.oc;
            endcase
          end
          // Bottom wins over match: compare at max holds level
          if (at_max && st_ff.com[1]) begin
            nxt_st.oc = ~st_ff.com[0];
          end
        end
        default: begin
          nxt_st.oc = st_ff.oc;
        end
      endcase

      // Buffered compare moves in at wrap to bottom
      if (is_pwm(st_ff.wave_mode) && at_max) begin
        nxt_st.ocr_act = st_ff.ocr_buf;
      end
    end

    if (wr_en) begin
      case (wr_addr)
        `TMWC_OFF_CTRL: begin
          // New output mode used at once by the pin select and a forced match
          nxt_st.wave_mode = tmwc_pkg::tmwc_wave_t'(
                               hwdata_in[`TMWC_CTRL_WAVE_LSB +: 2]);
          nxt_st.com       = wr_com;
          if (forced) begin
            // Forced match: state only, counter and flag left
            nxt_st.oc = match_action(wr_com, st_ff.oc);
          end
        end
        `TMWC_OFF_COUNT: begin
          // Software write beats tick count and clear
          nxt_st.count = hwdata_in[7:0];
          nxt_st.block = 1'b1;
        end
        `TMWC_OFF_COMPARE: begin
          nxt_st.ocr_buf = hwdata_in[7:0];
          if (!is_pwm(st_ff.wave_mode)) begin
            nxt_st.ocr_act = hwdata_in[7:0];
          end
        end
        `TMWC_OFF_PORT: begin
          nxt_st.port_data = hwdata_in[`TMWC_PORT_DATA];
          nxt_st.dir       = hwdata_in[`TMWC_PORT_DIR];
        end
        default: begin
          nxt_st.dir = st_ff.dir;
        end
      endcase
    end

    nxt_st.pin_lvl = pin_sync;
    // Override chosen by output mode alone
    if (nxt_st.com != 2'h0) begin
      nxt_st.pin_drive = nxt_st.oc;
    end else begin
      nxt_st.pin_drive = nxt_st.port_data;
    end

    // Read data sampled at address phase, held through data phase
    if (ap_req.valid && !ap_req.write) begin
      nxt_st.rdata = read_mux(ap_req.addr, st_ff);
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      st_ff           <= '0;
      st_ff.wave_mode <= tmwc_pkg::WM_NORMAL;
      st_ff.count     <= `TMWC_RST_BYTE;
      st_ff.ocr_act   <= `TMWC_RST_BYTE;
      st_ff.ocr_buf   <= `TMWC_RST_BYTE;
      st_ff.rdata     <= `TMWC_RST_WORD;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign hrdata_out        = st_ff.rdata;
  assign pin_out           = st_ff.pin_drive;
  // Driver enable follows direction bit even under override
  assign pin_oe_out        = st_ff.dir;
  assign overflow_flag_out = st_ff.ovf;
  assign match_flag_out    = st_ff.mtf;

endmodule : tmwc_top

// [tb/tb_top.sv]
`timescale 1ns/10ps
`include "tmwc_defines.svh"
module tb_top;
  logic        clk_in = 1'b0;
  logic        nrst_in = 1'b0;
  logic        tick = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd_s;
  logic        hrdy, hresp, pin_lvl, pin_out, pin_oe, ovf, mtf;
  logic        ext_en = 1'b0;
  logic        ext_val = 1'b0;
  int          miscompares = 0;
  int          num_checks = 0;
  int          cyc = 0;
  always #2 clk_in = ~clk_in;
  tmwc_top dut_u (.clk_in(clk_in), .nrst_in(nrst_in), .timer_tick_in(tick),
    .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
    .hsize_in(3'h2), .hready_in(hrdy), .hwdata_in(hwdata),
    .hrdata_out(hrdata), .hreadyout_out(hrdy), .hresp_out(hresp),
    .pin_in(pin_lvl), .pin_out(pin_out), .pin_oe_out(pin_oe),
    .overflow_flag_out(ovf), .match_flag_out(mtf));
  tmwc_pin_model pin_u (.clk_in(clk_in), .drive_in(pin_out), .oe_in(pin_oe),
    .ext_en_in(ext_en), .ext_val_in(ext_val), .level_out(pin_lvl));
  task automatic complete_run;
    if (miscompares == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input string nm, input logic [31:0] e, g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Samples ready and read data at the rising edge, before the design moves
  task automatic wait_rdy;
    @(posedge clk_in);
    while (hrdy !== 1'b1) @(posedge clk_in);
    rd_s = hrdata;
  endtask : wait_rdy
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
  endtask : bus
  // Random gaps between ticks mimic a prescaled enable
  task automatic ticks(input int n);
    int g;
    repeat (n) begin
      g = $urandom % 2;
      tick <= 1'b1;
      @(posedge clk_in);
      if (g == 1) begin
        tick <= 1'b0;
        @(posedge clk_in);
      end
    end
    tick <= 1'b0;
    @(posedge clk_in);
  endtask : ticks
  // First tick after a count write never matches
  function automatic logic [10:0] predict(input logic [1:0] m, com,
    input logic [7:0] x, ca, cb, input int n, input logic oc);
    logic ov, mt, hit;
    ov = 1'b0;
    mt = 1'b0;
    for (int i = 0; i < n; i++) begin
      hit = x == ca && i != 0;
      mt |= hit;
      if (x == 8'hff) ov = 1'b1;
      if (hit && com != 2'h0) oc = (com == 2'h1) ? ~oc : com[0];
      if (m == 2'h3 && x == 8'hff) begin
        if (com[1]) oc = ~com[0];
        ca = cb;
      end
      x = (m == 2'h2 && hit) ? 8'h00 : x + 8'h01;
    end
    return {oc, ov, mt, x};
  endfunction : predict
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      miscompares++;
      complete_run();
    end
  end
  initial begin
    logic [1:0]  m, com;
    logic [7:0]  x, c, d;
    logic [10:0] e;
    logic        oc, dir, dat, pv;
    int          n;
    void'($urandom(41));
    repeat (20) @(posedge clk_in);
    nrst_in <= 1'b1;
    @(posedge clk_in);
    for (int a = 0; a < 6; a++) begin
      bus(1'b0, 8'(a * 4), 32'h0);
      chk("reset value", 32'h0, rd_s & ~32'h4);
    end
    bus(1'b1, 8'h14, 32'hffff_ffff);
    bus(1'b0, 8'h14, 32'h0);
    chk("unmapped", 32'h0, rd_s);
    for (int t = 0; t < 24; t++) begin
      m = (t % 3 == 0) ? 2'h0 : ((t % 3 == 1) ? 2'h2 : 2'h3);
      com = 2'(t / 3);
      x = 8'($urandom);
      c = (t % 4 != 0) ? 8'($urandom) : ((t % 8 == 0) ? 8'h00 : 8'hff);
      d = (t % 4 != 0) ? 8'($urandom) : c;
      n = 1 + $urandom % 300;
      {oc, dir, dat} = 3'($urandom);
      bus(1'b1, `TMWC_OFF_CTRL, {24'h0, 2'h2, oc ? 2'h3 : 2'h2, 4'h0});
      bus(1'b1, `TMWC_OFF_COMPARE, {24'h0, c});
      bus(1'b1, `TMWC_OFF_CTRL, {26'h0, com, 2'h0, m});
      bus(1'b1, `TMWC_OFF_COUNT, {24'h0, x});
      bus(1'b1, `TMWC_OFF_COMPARE, {24'h0, d});
      bus(1'b1, `TMWC_OFF_STATUS, 32'h3);
      bus(1'b1, `TMWC_OFF_PORT, {30'h0, dir, dat});
      ext_en <= ~dir;
      ext_val <= 1'($urandom);
      ticks(n);
      e = predict(m, com, x, (m == 2'h3) ? c : d, d, n, oc);
      pv = (com != 2'h0) ? e[10] : dat;
      bus(1'b0, `TMWC_OFF_COUNT, 32'h0);
      chk("count", 32'(e[7:0]), rd_s);
      chk("overflow", 32'(e[9]), 32'(ovf));
      chk("match", 32'(e[8]), 32'(mtf));
      chk("pin", 32'(pv), 32'(pin_out));
      chk("enable", 32'(dir), 32'(pin_oe));
      // Pin level needs the synchroniser plus one register to settle
      repeat (6) @(posedge clk_in);
      bus(1'b0, `TMWC_OFF_PORT, 32'h0);
      chk("port", {29'h0, dir ? pv : ext_val, dir, dat}, rd_s);
      if (m != 2'h3) begin
        bus(1'b1, `TMWC_OFF_CTRL, {24'h0, 2'h2, com, 2'h0, m});
        @(negedge clk_in);
        pv = (com == 2'h0) ? dat : ((com == 2'h1) ? ~e[10] : com[0]);
        chk("force pin", 32'(pv), 32'(pin_out));
        chk("force flag", 32'(e[8]), 32'(mtf));
        bus(1'b0, `TMWC_OFF_COUNT, 32'h0);
        chk("force count", 32'(e[7:0]), rd_s);
      end
    end
    complete_run();
  end
endmodule : tb_top

// [tb/tmwc_pin_model.sv]
`timescale 1ns/10ps
module tmwc_pin_model (
  input  wire logic clk_in,
  input  wire logic drive_in,
  input  wire logic oe_in,
  input  wire logic ext_en_in,
  input  wire logic ext_val_in,
  output logic      level_out
);
  logic last_ff = 1'b0;
  always_ff @(posedge clk_in) begin
    last_ff <= level_out;
  end
  // Floating pin keeps flipping so a stale value never passes
  always_comb begin
    if (oe_in) begin
      level_out = drive_in;
    end else if (ext_en_in) begin
      level_out = ext_val_in;
    end else begin
      level_out = ~last_ff;
    end
  end
endmodule : tmwc_pin_model

// [tb/tmwc_sva.sv]
`timescale 1ns/10ps
`include "tmwc_defines.svh"
module tmwc_sva (
  input wire logic        clk_in,
  input wire logic        nrst_in,
  input wire logic        timer_tick_in,
  input wire logic        hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0]  htrans_in,
  input wire logic        hwrite_in,
  input wire logic        hready_in,
  input wire logic [31:0] hwdata_in,
  input wire logic        pin_out,
  input wire logic        pin_oe_out,
  input wire logic        overflow_flag_out,
  input wire logic        match_flag_out
);
  logic       wr_ff;
  logic [7:0] adr_ff;
  logic [1:0] com_ff;
  wire st_wr = wr_ff && adr_ff == `TMWC_OFF_STATUS;
  wire port_wr = wr_ff && adr_ff == `TMWC_OFF_PORT;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  // Data phase tracker; output mode mirrored for the pass-through check
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      wr_ff  <= 1'b0;
      adr_ff <= 8'h00;
      com_ff <= 2'h0;
    end else begin
      wr_ff  <= hsel_in && htrans_in[1] && hready_in && hwrite_in;
      adr_ff <= haddr_in[7:0];
      if (wr_ff && adr_ff == `TMWC_OFF_CTRL) begin
        com_ff <= hwdata_in[5:4];
      end
    end
  end
  a_ovf_on_tick: assert property ($rose(overflow_flag_out)
    |-> $past(timer_tick_in)) else $error("Overflow rose without tick");
  a_mtf_on_tick: assert property ($rose(match_flag_out)
    |-> $past(timer_tick_in)) else $error("Match rose without tick");
  a_ovf_sw_clear: assert property ($fell(overflow_flag_out)
    |-> $past(st_wr && hwdata_in[0])) else $error("Overflow lost");
  a_mtf_sw_clear: assert property ($fell(match_flag_out)
    |-> $past(st_wr && hwdata_in[1])) else $error("Match flag lost");
  a_oe_by_port: assert property ($changed(pin_oe_out)
    |-> $past(port_wr)) else $error("Pin enable moved alone");
  a_oe_value: assert property (port_wr
    |=> pin_oe_out == $past(hwdata_in[1])) else $error("Pin enable wrong");
  a_pin_on_event: assert property ($changed(pin_out)
    |-> $past(timer_tick_in || wr_ff)) else $error("Pin moved alone");
  a_port_pass: assert property (port_wr && com_ff == 2'h0
    |=> pin_out == $past(hwdata_in[0])) else $error("Port data not on pin");
endmodule : tmwc_sva
bind tmwc_top tmwc_sva chk_u (
  .clk_in(clk_in), .nrst_in(nrst_in), .timer_tick_in(timer_tick_in),
  .hsel_in(hsel_in), .haddr_in(haddr_in), .htrans_in(htrans_in),
  .hwrite_in(hwrite_in), .hready_in(hready_in), .hwdata_in(hwdata_in),
  .pin_out(pin_out), .pin_oe_out(pin_oe_out),
  .overflow_flag_out(overflow_flag_out), .match_flag_out(match_flag_out));
